// File: rtl/prcp_pkg.sv
// Package for the paged register control port: constants and carriers
package prcp_pkg;
  // Page register lives at index 0 of every page
  localparam logic [6:0] PAGE_SELECT_IDX = 7'h00;
  localparam logic [7:0] PAGE_SELECT_RST = 8'h00;
  // Fixed upper bits of the two-wire slave address
  localparam logic [4:0] ADDR_FIXED_HI = 5'h12;
  localparam logic [1:0] ADDR_BCAST_LO = 2'h0;
  // Bit and register counts
  localparam int BYTE_BITS = 8;
  localparam int REGS_PER_PAGE = 128;

  // Register access request towards the register store
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] page;
    logic [6:0] idx;
    logic [7:0] wdata;
  } prcp_req_t;

  // Two-wire engine states
  typedef enum logic [2:0] {
    TW_IDLE = 3'b000,
    TW_ADDR = 3'b001,
    TW_AACK = 3'b010,
    TW_RXB = 3'b011,
    TW_RACK = 3'b100,
    TW_TXB = 3'b101,
    TW_TACK = 3'b110
  } prcp_tw_state_t;
endpackage : prcp_pkg

// File: rtl/prcp_sync.sv
// Two flip-flop synchroniser for one pin, with edge detection on the stable copy
`timescale 1ns/10ps
module prcp_sync #(
  parameter logic RST_VAL = 1'b1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pin,
  output logic level,
  output logic rise,
  output logic fall
);
  logic meta_q;
  logic sync_q;
  logic prev_q;

  // First flop feeds only the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
      prev_q <= RST_VAL;
    end else begin
      meta_q <= pin;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // Edges seen on the settled copy only
  assign level = sync_q;
  assign rise = sync_q & ~prev_q;
  assign fall = ~sync_q & prev_q;
endmodule : prcp_sync

// File: rtl/prcp_regstore.sv
// Register store: page select register plus a flat array of paged bytes
`timescale 1ns/10ps
module prcp_regstore #(
  parameter int NUM_PAGES = 5
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic soft_reset,
  input wire prcp_pkg::prcp_req_t req,
  output logic [7:0] rdata,
  output logic [7:0] page_q
);
  logic [7:0] mem_q [NUM_PAGES*prcp_pkg::REGS_PER_PAGE];
  logic [7:0] rdata_d;
  logic in_range;

  assign in_range = (req.page < 8'(NUM_PAGES));

  // Page register: index 0 of any page, reset to page 0
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      page_q <= prcp_pkg::PAGE_SELECT_RST;
    end else if (soft_reset) begin
      page_q <= prcp_pkg::PAGE_SELECT_RST;
    end else if (req.wr && req.idx == prcp_pkg::PAGE_SELECT_IDX) begin
      page_q <= req.wdata;
    end
  end

  // Backing bytes; no reset so it maps onto RAM
  always_ff @(posedge clk) begin
    if (req.wr && in_range && req.idx != prcp_pkg::PAGE_SELECT_IDX) begin
      mem_q[{req.page[2:0], req.idx}] <= req.wdata;
    end
  end

  // Reserved pages read as zero except at index 0, which returns the page register
  always_comb begin
    rdata_d = 8'h00;
    if (req.idx == prcp_pkg::PAGE_SELECT_IDX) begin
      rdata_d = page_q;
    end else if (in_range) begin
      rdata_d = mem_q[{req.page[2:0], req.idx}];
    end
  end
  assign rdata = rdata_d;
endmodule : prcp_regstore

// File: rtl/prcp_top.sv
// Control port slave: two-wire and four-wire serial access to paged registers
`timescale 1ns/10ps
module prcp_top #(
  parameter int NUM_PAGES = 5
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic soft_reset,
  input wire logic broadcast_addr_enable,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic serial_select_low,
  input wire logic strap_bit0_pin,
  input wire logic strap_bit1_pin,
  output logic miso_out,
  output logic miso_oe,
  output logic four_wire_mode,
  output logic [7:0] active_page
);
  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic scl_s, scl_r, scl_f;
  logic sda_s, sda_r, sda_f;
  logic ssl_s, ssl_f;
  logic sclk_s, sclk_r, sclk_f;
  logic st1_s;

  prcp_sync #(.RST_VAL(1'b1)) u_scl (.clk(clk), .rst_n(rst_n), .pin(scl_in),
    .level(scl_s), .rise(scl_r), .fall(scl_f));
  prcp_sync #(.RST_VAL(1'b1)) u_sda (.clk(clk), .rst_n(rst_n), .pin(sda_in),
    .level(sda_s), .rise(sda_r), .fall(sda_f));
  prcp_sync #(.RST_VAL(1'b1)) u_ssl (.clk(clk), .rst_n(rst_n), .pin(serial_select_low),
    .level(ssl_s), .rise(), .fall(ssl_f));
  prcp_sync #(.RST_VAL(1'b0)) u_sclk (.clk(clk), .rst_n(rst_n), .pin(strap_bit0_pin),
    .level(sclk_s), .rise(sclk_r), .fall(sclk_f));
  prcp_sync #(.RST_VAL(1'b0)) u_st1 (.clk(clk), .rst_n(rst_n), .pin(strap_bit1_pin),
    .level(st1_s), .rise(), .fall());

  ////////////////////////////////////////////////////////////////////////
  // Protocol selection
  // Select has its own pin; a select fall while the serial clock and SCL (MOSI) pins are both low means four-wire
  logic spi_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      spi_q <= 1'b0;
    end else if (ssl_f && !sclk_s && !scl_s) begin
      spi_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Shared register access
  prcp_pkg::prcp_req_t req;
  logic [7:0] rdata;
  logic [7:0] page_q;
  logic [6:0] idx_q;
  logic [7:0] shreg_q;
  logic [3:0] bits_q;
  logic wr_pulse_q;
  logic [7:0] wdata_q;
  logic ld_q;
  logic [7:0] tx_q;

  always_comb begin
    req = '0;
    req.wr = wr_pulse_q;
    req.page = page_q;
    req.idx = idx_q;
    req.wdata = wdata_q;
  end

  prcp_regstore #(.NUM_PAGES(NUM_PAGES)) u_regs (.clk(clk), .rst_n(rst_n),
    .soft_reset(soft_reset), .req(req), .rdata(rdata), .page_q(page_q));

  // Soft reset must win over a page write landing in the same cycle
  chk_page_reset: assert property (
    @(posedge clk) disable iff (!rst_n) soft_reset |=> page_q == prcp_pkg::PAGE_SELECT_RST)
    else $error("page select not cleared by soft reset");

  // Index zero of any page retargets the active page
  chk_page_write: assert property (
    @(posedge clk) disable iff (!rst_n)
    req.wr && req.idx == prcp_pkg::PAGE_SELECT_IDX && !soft_reset |=> page_q == $past(req.wdata))
    else $error("page select missed a write to index zero");

  ////////////////////////////////////////////////////////////////////////
  // Two-wire engine
  prcp_pkg::prcp_tw_state_t tw_q;
  logic rw_q;
  logic idx_seen_q;
  logic [6:0] my_addr;
  logic start_c, stop_c;

  // Start and stop only while SCL is high
  assign start_c = sda_f && scl_s && !spi_q;
  assign stop_c = sda_r && scl_s && !spi_q;
  assign my_addr = {prcp_pkg::ADDR_FIXED_HI,
    broadcast_addr_enable ? prcp_pkg::ADDR_BCAST_LO : {st1_s, sclk_s}};

  // Byte framing, acknowledge and auto-increment; no byte limit per frame
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tw_q <= prcp_pkg::TW_IDLE;
      rw_q <= 1'b0;
      idx_seen_q <= 1'b0;
      bits_q <= 4'h0;
      shreg_q <= 8'h00;
      idx_q <= 7'h00;
      wr_pulse_q <= 1'b0;
      wdata_q <= 8'h00;
      sda_out <= 1'b1;
      sda_oe <= 1'b0;
      ld_q <= 1'b0;
      tx_q <= 8'h00;
      miso_out <= 1'b0;
      miso_oe <= 1'b0;
    end else begin
      wr_pulse_q <= 1'b0;
      if (spi_q) begin
        // Four-wire frames own the shared state; data line stays released
        sda_oe <= 1'b0;
        if (ssl_s) begin
          // Select high: idle, counter cleared, output released
          bits_q <= 4'h0;
          idx_seen_q <= 1'b0;
          ld_q <= 1'b0;
          tx_q <= 8'h00;
          miso_oe <= 1'b0;
        end else begin
          miso_oe <= 1'b1;
          if (ld_q) begin
            // Index settled one cycle earlier, so the store answers now
            ld_q <= 1'b0;
            tx_q <= rdata;
          end else if (sclk_r) begin
            // Launch on the rising clock; host samples on the falling one
            miso_out <= tx_q[7];
            tx_q <= {tx_q[6:0], 1'b0};
          end else if (sclk_f) begin
            // Capture on the falling clock, MSB first
            shreg_q <= {shreg_q[6:0], scl_s};
            bits_q <= {1'b0, bits_q[2:0] + 3'h1};
            if (bits_q[2:0] == 3'h7) begin
              if (!idx_seen_q) begin
                // Command: seven index bits, then direction
                idx_q <= shreg_q[6:0];
                rw_q <= scl_s;
                idx_seen_q <= 1'b1;
                ld_q <= scl_s;
              end else if (rw_q) begin
                idx_q <= idx_q + 7'h01;
                ld_q <= 1'b1;
              end else begin
                wdata_q <= {shreg_q[6:0], scl_s};
                wr_pulse_q <= 1'b1;
              end
            end
          end
        end
      end else if (start_c) begin
        tw_q <= prcp_pkg::TW_ADDR;
        bits_q <= 4'h0;
        sda_oe <= 1'b0;
      end else if (stop_c) begin
        tw_q <= prcp_pkg::TW_IDLE;
        sda_oe <= 1'b0;
      end else begin
        unique case (tw_q)
          prcp_pkg::TW_IDLE: begin
            sda_oe <= 1'b0;
          end
          prcp_pkg::TW_ADDR, prcp_pkg::TW_RXB: begin
            if (scl_r) begin
              shreg_q <= {shreg_q[6:0], sda_s};
              bits_q <= bits_q + 4'h1;
            end else if (scl_f && bits_q == 4'(prcp_pkg::BYTE_BITS)) begin
              bits_q <= 4'h0;
              if (tw_q == prcp_pkg::TW_ADDR) begin
                if (shreg_q[7:1] == my_addr) begin
                  rw_q <= shreg_q[0];
                  idx_seen_q <= 1'b0;
                  sda_oe <= 1'b1;
                  sda_out <= 1'b0;
                  tw_q <= prcp_pkg::TW_AACK;
                end else begin
                  tw_q <= prcp_pkg::TW_IDLE;
                end
              end else begin
                if (!idx_seen_q) begin
                  idx_q <= shreg_q[6:0];
                  idx_seen_q <= 1'b1;
                end else begin
                  wdata_q <= shreg_q;
                  wr_pulse_q <= 1'b1;
                end
                sda_oe <= 1'b1;
                sda_out <= 1'b0;
                tw_q <= prcp_pkg::TW_RACK;
              end
            end
          end
          prcp_pkg::TW_AACK, prcp_pkg::TW_RACK: begin
            // Release or load on SCL low only
            if (scl_f) begin
              if (rw_q && tw_q == prcp_pkg::TW_AACK) begin
                shreg_q <= rdata;
                sda_out <= rdata[7];
                sda_oe <= ~rdata[7];
                bits_q <= 4'h1;
                tw_q <= prcp_pkg::TW_TXB;
              end else begin
                sda_oe <= 1'b0;
                tw_q <= prcp_pkg::TW_RXB;
              end
            end
          end
          prcp_pkg::TW_TXB: begin
            // Open-drain: drive only zeros, change on SCL fall
            if (scl_f) begin
              if (bits_q == 4'(prcp_pkg::BYTE_BITS)) begin
                sda_oe <= 1'b0;
                idx_q <= idx_q + 7'h01;
                tw_q <= prcp_pkg::TW_TACK;
              end else begin
                sda_out <= shreg_q[7 - bits_q[2:0]];
                sda_oe <= ~shreg_q[7 - bits_q[2:0]];
                bits_q <= bits_q + 4'h1;
              end
            end
          end
          prcp_pkg::TW_TACK: begin
            if (scl_r) begin
              // Master NACK ends the read
              tw_q <= sda_s ? prcp_pkg::TW_IDLE : prcp_pkg::TW_AACK;
            end
          end
          default: tw_q <= prcp_pkg::TW_IDLE;
        endcase
      end
      // Index steps after each stored data byte, on either bus
      if (wr_pulse_q) begin
        idx_q <= idx_q + 7'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks on the serial sides
  // Drive changes are launched from a seen clock fall, so SCL is still low
  chk_sda_low_phase: assert property (
    @(posedge clk) disable iff (!rst_n) $changed(sda_oe) |-> !scl_s)
    else $error("data line drive changed while clock high");

  // Counter never runs past one byte
  chk_bit_count: assert property (
    @(posedge clk) disable iff (!rst_n) bits_q <= 4'(prcp_pkg::BYTE_BITS))
    else $error("bit counter ran past one byte");

  // A matching address is acknowledged by pulling the line low
  chk_addr_ack: assert property (
    @(posedge clk) disable iff (!rst_n)
    !spi_q && tw_q == prcp_pkg::TW_ADDR && scl_f && bits_q == 4'(prcp_pkg::BYTE_BITS)
      && shreg_q[7:1] == my_addr |=> sda_oe && !sda_out && tw_q == prcp_pkg::TW_AACK)
    else $error("matching address not acknowledged");

  // Another device's address leaves the line alone
  chk_miss_no_ack: assert property (
    @(posedge clk) disable iff (!rst_n)
    !spi_q && tw_q == prcp_pkg::TW_ADDR && scl_f && bits_q == 4'(prcp_pkg::BYTE_BITS)
      && shreg_q[7:1] != my_addr |=> tw_q == prcp_pkg::TW_IDLE && !sda_oe)
    else $error("foreign address was answered");

  // Output released one cycle after select is seen high
  chk_miso_released: assert property (
    @(posedge clk) disable iff (!rst_n) ssl_s |=> !miso_oe)
    else $error("four-wire output driven while deselected");

  // Output only moves after a rising serial clock
  chk_miso_launch: assert property (
    @(posedge clk) disable iff (!rst_n) $changed(miso_out) |-> $past(sclk_r))
    else $error("four-wire output moved off the rising clock");

  assign four_wire_mode = spi_q;
  assign active_page = page_q;
endmodule : prcp_top

// File: testbench/prcp_host.sv
// Host model: two-wire and four-wire bus master with a 200 ns serial clock
`timescale 1ns/10ps
module prcp_host (
  input wire logic clk,
  input wire logic sda,
  input wire logic miso,
  output logic scl = 1'b1,
  output logic sda_low = 1'b0,
  output logic sclk = 1'b0,
  output logic ss_n = 1'b1
);
  // Quarter serial period; every change lands on a falling system clock edge
  task automatic q();
    repeat (2) @(negedge clk);
  endtask : q
  // Data falls while the clock is high
  task automatic start();
    sda_low = 1'b0;
    q();
    scl = 1'b1;
    q();
    sda_low = 1'b1;
    q();
    scl = 1'b0;
    q();
  endtask : start
  // Data rises while the clock is high
  task automatic stop();
    sda_low = 1'b1;
    q();
    scl = 1'b1;
    q();
    sda_low = 1'b0;
    q();
  endtask : stop
  // One clock pulse; data only moves while the clock is low
  task automatic bit_x(input logic b, output logic r);
    sda_low = ~b;
    q();
    scl = 1'b1;
    q();
    r = sda;
    q();
    scl = 1'b0;
    q();
  endtask : bit_x
  // MSB first, ninth clock samples the answer
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(b[i], r);
    bit_x(1'b1, r);
    ack = ~r;
  endtask : wbyte
  // Acknowledge all but the last byte, which gets a refusal
  task automatic rbyte(output logic [7:0] b, input logic more);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, b[i]);
    bit_x(~more, r);
  endtask : rbyte
  // Four-wire frame on the shared pins: MOSI moves on the rising clock,
  // MISO is sampled on the falling one; select stays low throughout
  task automatic sframe(input logic [7:0] cmd, input logic [7:0] d[$],
      output logic [7:0] r[$]);
    logic [7:0] w[$];
    logic [7:0] b;
    w = d;
    w.push_front(cmd);
    r = {};
    scl = 1'b0;
    q();
    ss_n = 1'b0;
    q();
    q();
    foreach (w[k]) begin
      for (int i = 7; i >= 0; i--) begin
        sclk = 1'b1;
        scl = w[k][i];
        q();
        q();
        sclk = 1'b0;
        b[i] = miso;
        q();
        q();
      end
      r.push_back(b);
    end
    ss_n = 1'b1;
    q();
    q();
    scl = 1'b1;
    q();
  endtask : sframe
endmodule : prcp_host

// File: testbench/prcp_top_tb_top.sv
// Testbench for the control port: two-wire and four-wire register traffic against the host model
`timescale 1ns/10ps
module prcp_top_tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic soft_reset = 1'b0;
  logic bcast = 1'b0;
  logic [1:0] strap = 2'b00;
  logic scl, sda_low, sda, sda_out, sda_oe, four_wire;
  logic [7:0] page;
  logic sclk, ss_n, miso, miso_out, miso_oe;
  int error_cnt = 0;
  int n_tests = 0;

  ////////////////////////////////////////////////////////////////////////////
  always #12.5 clk = ~clk;
  // Wired-AND data line with pull-up; either party may pull low
  assign sda = ~(sda_low | (sda_oe & ~sda_out));
  // Released MISO floats up to its pull-up level
  assign miso = miso_oe ? miso_out : 1'b1;
  // Serial clock shares the low strap pin, MOSI shares the two-wire clock pin
  prcp_top #(.NUM_PAGES(5)) uut (.clk(clk), .rst_n(rst_n), .soft_reset(soft_reset),
    .broadcast_addr_enable(bcast), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .serial_select_low(ss_n), .strap_bit0_pin(strap[0] | sclk),
    .strap_bit1_pin(strap[1]), .miso_out(miso_out), .miso_oe(miso_oe),
    .four_wire_mode(four_wire), .active_page(page));
  prcp_host host (.clk(clk), .sda(sda), .miso(miso), .scl(scl), .sda_low(sda_low),
    .sclk(sclk), .ss_n(ss_n));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic summarize();
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : summarize
  function automatic logic [6:0] dev();
    return {prcp_pkg::ADDR_FIXED_HI, strap};
  endfunction : dev
  // Index byte then consecutive data; every byte answered as ok says
  task automatic wr(logic [6:0] a7, logic [7:0] idx, logic [7:0] d[$], logic ok);
    logic a;
    host.start();
    host.wbyte({a7, 1'b0}, a);
    check("address ack", a, ok);
    host.wbyte(idx, a);
    check("index ack", a, ok);
    foreach (d[i]) begin
      host.wbyte(d[i], a);
      check("data ack", a, ok);
    end
    host.stop();
  endtask : wr
  // Index write, repeated start, then reads until the refused byte
  task automatic rd(logic [7:0] idx, logic [7:0] e[$]);
    logic a;
    logic [7:0] b;
    host.start();
    host.wbyte({dev(), 1'b0}, a);
    host.wbyte(idx, a);
    host.start();
    host.wbyte({dev(), 1'b1}, a);
    check("read address ack", a, 8'h01);
    foreach (e[i]) begin
      host.rbyte(b, i < e.size() - 1);
      check("read data", b, e[i]);
    end
    host.stop();
  endtask : rd

  ////////////////////////////////////////////////////////////////////////////
  // Burst writes stay in their own page; a page 2 write leaves the page 3 burst intact
  task automatic t_pages();
    wr(dev(), 8'h00, '{8'h03}, 1'b1);
    check("active page", page, 8'h03);
    wr(dev(), 8'h10, '{8'hA1, 8'h5C, 8'h3E, 8'h07, 8'hF0}, 1'b1);
    wr(dev(), 8'h00, '{8'h02}, 1'b1);
    wr(dev(), 8'h10, '{8'h69}, 1'b1);
    wr(dev(), 8'h00, '{8'h03}, 1'b1);
    rd(8'h10, '{8'hA1, 8'h5C, 8'h3E, 8'h07, 8'hF0});
    rd(8'h00, '{8'h03});
  endtask : t_pages
  // Each strap pair gives its own address; the complemented strap address must not write
  task automatic t_addr();
    for (int s = 0; s < 4; s++) begin
      @(negedge clk);
      strap = 2'(s);
      wr(dev(), 8'h00, '{8'h01}, 1'b1);
      wr({prcp_pkg::ADDR_FIXED_HI, ~strap}, 8'h00, '{8'h04}, 1'b0);
      check("page after miss", page, 8'h01);
    end
    @(negedge clk);
    bcast = 1'b1;
    wr(dev(), 8'h00, '{8'h04}, 1'b0);
    wr({prcp_pkg::ADDR_FIXED_HI, prcp_pkg::ADDR_BCAST_LO}, 8'h00, '{8'h02}, 1'b1);
    check("page by broadcast", page, 8'h02);
    @(negedge clk);
    bcast = 1'b0;
    strap = 2'b00;
  endtask : t_addr
  // Software reset must bring the active page back to zero
  task automatic t_soft();
    wr(dev(), 8'h00, '{8'h04}, 1'b1);
    check("active page", page, 8'h04);
    @(negedge clk);
    soft_reset = 1'b1;
    @(negedge clk);
    soft_reset = 1'b0;
    repeat (4) @(negedge clk);
    check("page after soft reset", page, prcp_pkg::PAGE_SELECT_RST);
    rd(8'h00, '{8'h00});
  endtask : t_soft
  // Mid-run reset, then four-wire frames; a select fall with clock and MOSI low picks them
  task automatic t_spi();
    logic [7:0] r[$];
    wr(dev(), 8'h00, '{8'h01}, 1'b1);
    @(negedge clk);
    rst_n = 1'b0;
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    check("page after reset", page, prcp_pkg::PAGE_SELECT_RST);
    check("two-wire after reset", 8'(four_wire), 8'h00);
    host.sframe({7'h00, 1'b0}, '{8'h02}, r);
    check("four-wire mode", 8'(four_wire), 8'h01);
    check("four-wire page", page, 8'h02);
    host.sframe({7'h20, 1'b0}, '{8'h5A, 8'hC3}, r);
    host.sframe({7'h20, 1'b1}, '{8'h00, 8'h00}, r);
    check("four-wire read", r[1], 8'h5A);
    check("four-wire next read", r[2], 8'hC3);
    host.sframe({7'h00, 1'b1}, '{8'h00}, r);
    check("four-wire page read", r[1], 8'h02);
    check("miso released", 8'(miso_oe), 8'h00);
  endtask : t_spi

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    check("page at reset", page, prcp_pkg::PAGE_SELECT_RST);
    t_pages();
    t_addr();
    t_soft();
    t_spi();
    summarize();
  end
  // Watchdog: the sequence needs well under a third of this span
  initial begin
    #2000000;
    error_cnt++;
    summarize();
  end
endmodule : prcp_top_tb_top
